// >>> hdl/uei_pkg.sv
/*
 * Package for the endpoint interrupt summary block: register addresses,
 * field positions, reset values and widths.
 * Assumes an 8-bit special function register bus with 8-bit addresses.
 */
package uei_pkg;

    localparam int          NUM_EP              = 7;
    localparam int          SRC_PER_EP          = 5;
    localparam int          ADDR_W              = 8;
    localparam int          DATA_W              = 8;

    // Register addresses on the special function bus.
    localparam logic [7:0]  ADDR_EP_IRQ_PENDING = 8'hf8;
    localparam logic [7:0]  ADDR_EP_IRQ_ENABLE  = 8'hc2;
    localparam logic [7:0]  ADDR_EP_SELECT      = 8'hc7;
    localparam logic [7:0]  ADDR_EP_STATUS_WIN  = 8'hc8;
    localparam logic [7:0]  ADDR_IRQ_STATUS     = 8'hc9;
    localparam logic [7:0]  ADDR_IRQ_MASK       = 8'hca;

    // Source bit positions in one endpoint status word.
    localparam int          SRC_TX_COMPLETE     = 0;
    localparam int          SRC_OUT_BANK_A      = 1;
    localparam int          SRC_OUT_BANK_B      = 2;
    localparam int          SRC_SETUP           = 3;
    localparam int          SRC_STALL_CRC       = 4;

    localparam int          EP_SEL_W            = 3;
    localparam logic [7:0]  RST_ZERO            = 8'h00;
    localparam logic [6:0]  RST_PENDING         = 7'h00;

endpackage

// >>> hdl/uei_ep_flag.sv
/*
 * One endpoint's summary flag: OR of its pending sources, registered.
 * Assumes the source flags come from logic on the same clock.
 */
module uei_ep_flag
    import uei_pkg::*;
(
    // Clock and reset.
    input  wire logic                  clk,
    input  wire logic                  rst,
    // Sources and flag.
    input  wire logic [SRC_PER_EP-1:0] sources,
    output logic                       pending
);

    logic pending_r;
    logic pending_nxt;

    always_comb
    begin
        pending_nxt = |sources;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            pending_r <= 1'b0;
        else
            pending_r <= pending_nxt;
    end

    assign pending = pending_r;

endmodule

// >>> hdl/uei_top.sv
/*
 * Endpoint interrupt summary: per-endpoint pending flags, endpoint enables,
 * endpoint select with status window, and a sticky status/mask interrupt.
 * Assumes source flags arrive on clk from the per-endpoint status logic,
 * and a bus master with one-cycle strobes and read data one cycle later.
 */
module uei_top
    import uei_pkg::*;
(
    // Clock and reset.
    input  wire logic                         clk,
    input  wire logic                         rst,
    // Register bus.
    input  wire logic [ADDR_W-1:0]            reg_addr,
    input  wire logic [DATA_W-1:0]            reg_wdata,
    input  wire logic                         reg_wr,
    input  wire logic                         reg_rd,
    output logic      [DATA_W-1:0]            reg_rdata,
    // Per-endpoint source flags.
    input  wire logic [NUM_EP-1:0]            transmit_complete,
    input  wire logic [NUM_EP-1:0]            out_received_bank_a,
    input  wire logic [NUM_EP-1:0]            out_received_bank_b,
    input  wire logic [NUM_EP-1:0]            setup_received,
    input  wire logic [NUM_EP-1:0]            stall_or_crc_error,
    // Endpoint selection for the status logic.
    output logic      [EP_SEL_W-1:0]          endpoint_select,
    // Interrupts.
    output logic                              usb_irq,
    output logic                              irq
);

    logic [NUM_EP-1:0]   pending;
    logic [NUM_EP-1:0]   enable_r;
    logic [NUM_EP-1:0]   enable_nxt;
    logic [EP_SEL_W-1:0] select_r;
    logic [EP_SEL_W-1:0] select_nxt;
    logic [NUM_EP-1:0]   pend_d_r;
    logic [NUM_EP-1:0]   status_r;
    logic [NUM_EP-1:0]   status_nxt;
    logic [NUM_EP-1:0]   mask_r;
    logic [NUM_EP-1:0]   mask_nxt;
    logic [DATA_W-1:0]   rdata_r;
    logic [DATA_W-1:0]   rdata_nxt;
    logic [SRC_PER_EP-1:0] win_src;
    logic                wr_enable;
    logic                wr_select;
    logic                wr_status;
    logic                wr_mask;

    // Gather each endpoint's sources into one word and summarise it.
    genvar g;
    generate
        for (g = 0; g < NUM_EP; g++)
        begin : g_ep
            logic [SRC_PER_EP-1:0] src;
            always_comb
            begin
                src                  = '0;
                src[SRC_TX_COMPLETE] = transmit_complete[g];
                src[SRC_OUT_BANK_A]  = out_received_bank_a[g];
                src[SRC_OUT_BANK_B]  = out_received_bank_b[g];
                src[SRC_SETUP]       = setup_received[g];
                src[SRC_STALL_CRC]   = stall_or_crc_error[g];
            end
            uei_ep_flag u_flag (
                .clk     (clk),
                .rst     (rst),
                .sources (src),
                .pending (pending[g])
            );
        end
    endgenerate

    // Status of the selected endpoint, seen through the window.
    always_comb
    begin
        win_src = '0;
        if (select_r < EP_SEL_W'(NUM_EP))
        begin
            win_src[SRC_TX_COMPLETE] = transmit_complete[select_r];
            win_src[SRC_OUT_BANK_A]  = out_received_bank_a[select_r];
            win_src[SRC_OUT_BANK_B]  = out_received_bank_b[select_r];
            win_src[SRC_SETUP]       = setup_received[select_r];
            win_src[SRC_STALL_CRC]   = stall_or_crc_error[select_r];
        end
    end

    assign wr_enable = reg_wr && (reg_addr == ADDR_EP_IRQ_ENABLE);
    assign wr_select = reg_wr && (reg_addr == ADDR_EP_SELECT);
    assign wr_status = reg_wr && (reg_addr == ADDR_IRQ_STATUS);
    assign wr_mask   = reg_wr && (reg_addr == ADDR_IRQ_MASK);

    // Register writes and sticky status; a rising flag wins over a clear.
    always_comb
    begin
        enable_nxt = enable_r;
        select_nxt = select_r;
        mask_nxt   = mask_r;
        status_nxt = status_r;
        if (wr_enable)
            enable_nxt = reg_wdata[NUM_EP-1:0];
        if (wr_select)
            select_nxt = reg_wdata[EP_SEL_W-1:0];
        if (wr_mask)
            mask_nxt = reg_wdata[NUM_EP-1:0];
        if (wr_status)
            status_nxt = status_nxt & ~reg_wdata[NUM_EP-1:0];
        status_nxt = status_nxt | (pending & ~pend_d_r);
    end

    // Read data; the summary register ignores writes and bit 7 is zero.
    always_comb
    begin
        rdata_nxt = '0;
        if (reg_rd)
        begin
            unique case (reg_addr)
                ADDR_EP_IRQ_PENDING: rdata_nxt = {1'b0, pending};
                ADDR_EP_IRQ_ENABLE:  rdata_nxt = {1'b0, enable_r};
                ADDR_EP_SELECT:      rdata_nxt = {{(DATA_W-EP_SEL_W){1'b0}}, select_r};
                ADDR_EP_STATUS_WIN:  rdata_nxt = {{(DATA_W-SRC_PER_EP){1'b0}}, win_src};
                ADDR_IRQ_STATUS:     rdata_nxt = {1'b0, status_r};
                ADDR_IRQ_MASK:       rdata_nxt = {1'b0, mask_r};
                default:             rdata_nxt = '0;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            enable_r <= RST_PENDING;
            select_r <= '0;
            mask_r   <= RST_PENDING;
            status_r <= RST_PENDING;
            pend_d_r <= RST_PENDING;
            rdata_r  <= RST_ZERO;
        end
        else
        begin
            enable_r <= enable_nxt;
            select_r <= select_nxt;
            mask_r   <= mask_nxt;
            status_r <= status_nxt;
            pend_d_r <= pending;
            rdata_r  <= rdata_nxt;
        end
    end

    assign reg_rdata       = rdata_r;
    assign endpoint_select = select_r;
    assign usb_irq         = |(pending & enable_r);
    assign irq             = |(status_r & mask_r);

endmodule

// >>> sim/uei_properties.sv
/* Checker for uei_top: read data, summary flags, enables, select, mask.
   Sees only the top module's ports; bound in from the bench. */
module uei_top_properties
    import uei_pkg::*;
(
    // Clock, reset and bus.
    input wire logic                clk, rst, reg_wr, reg_rd,
    input wire logic [ADDR_W-1:0]   reg_addr,
    input wire logic [DATA_W-1:0]   reg_wdata, reg_rdata,
    // Sources.
    input wire logic [NUM_EP-1:0]   transmit_complete, out_received_bank_a,
    input wire logic [NUM_EP-1:0]   out_received_bank_b, setup_received, stall_or_crc_error,
    // Select and interrupts.
    input wire logic [EP_SEL_W-1:0] endpoint_select,
    input wire logic                usb_irq, irq
);
    logic [NUM_EP-1:0] src_or;
    logic [NUM_EP-1:0] en_r;
    assign src_or = transmit_complete | out_received_bank_a | out_received_bank_b
                    | setup_received | stall_or_crc_error;
    // Shadow of the enable register, so the request line can be predicted.
    always_ff @(posedge clk)
        en_r <= rst ? '0 : (reg_wr && reg_addr == ADDR_EP_IRQ_ENABLE) ? reg_wdata[6:0] : en_r;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    rdata_idle_a:
        assert property (!$past(reg_rd) |-> reg_rdata == 8'h00) else $error("rdata not idle");
    pend_read_a:
        assert property ($past(reg_rd) && $past(reg_addr) == ADDR_EP_IRQ_PENDING
            |-> reg_rdata == {1'b0, $past(src_or, 2)}) else $error("pending read wrong");
    usb_req_a:
        assert property (usb_irq == |($past(src_or) & en_r)) else $error("usb_irq wrong");
    en_read_a:
        assert property ($past(reg_rd) && $past(reg_addr) == ADDR_EP_IRQ_ENABLE
            |-> reg_rdata == {1'b0, $past(en_r)}) else $error("enable read wrong");
    sel_set_a:
        assert property (reg_wr && reg_addr == ADDR_EP_SELECT
            |=> endpoint_select == $past(reg_wdata[2:0])) else $error("select not set");
    sel_hold_a:
        assert property (!(reg_wr && reg_addr == ADDR_EP_SELECT)
            |=> $stable(endpoint_select)) else $error("select changed");
    mask_off_a:
        assert property (reg_wr && reg_addr == ADDR_IRQ_MASK && reg_wdata == 8'h00
            |=> !irq) else $error("irq with mask clear");
    unmapped_a:
        assert property ($past(reg_rd) && $past(reg_addr) == 8'h00
            |-> reg_rdata == 8'h00) else $error("unmapped read not zero");
endmodule

// >>> sim/uei_top_bench.sv
/* Bench for uei_top: register reads and writes, source flags, interrupts.
   Assumes the package, design and checker files are compiled before it. */
module uei_top_bench
    import uei_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic                clk = 1'b0;
    logic                rst = 1'b1;
    logic                reg_wr = 1'b0;
    logic                reg_rd = 1'b0;
    logic [7:0]          reg_addr = 8'h00;
    logic [7:0]          reg_wdata = 8'h00;
    logic [7:0]          reg_rdata;
    logic [6:0]          src [5] = '{default: 7'h00};
    logic [EP_SEL_W-1:0] sel;
    logic                usb_irq;
    logic                irq;
    int                  err_count = 0;
    int                  n_compared = 0;
    int                  cyc = 0;
    always #25 clk = ~clk;
    uei_top dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .transmit_complete(src[0]),
        .out_received_bank_a(src[1]), .out_received_bank_b(src[2]), .setup_received(src[3]),
        .stall_or_crc_error(src[4]), .endpoint_select(sel), .usb_irq(usb_irq), .irq(irq));
    task automatic finish_test;
        if (err_count == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(string nm, logic [7:0] e, logic [7:0] s);
        n_compared++;
        if (s !== e)
        begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask
    // Writes leave one idle edge so the strobe never toggles twice in a step.
    task automatic wr(logic [7:0] a, logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
    endtask
    // Read data are taken mid-cycle, where they stand settled.
    task automatic rd(logic [7:0] a, logic [7:0] e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        chk("rdata", e, reg_rdata);
        @(posedge clk);
    endtask
    initial
    begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(ADDR_EP_IRQ_PENDING, 8'h00);
        rd(ADDR_EP_IRQ_ENABLE, 8'h00);
        for (int k = 0; k < SRC_PER_EP; k++)
        begin
            src[k] <= 7'h01 << k;
            repeat (2) @(posedge clk);
            rd(ADDR_EP_IRQ_PENDING, 8'h01 << k);
            src[k] <= 7'h00;
            repeat (2) @(posedge clk);
            rd(ADDR_EP_IRQ_PENDING, 8'h00);
        end
        for (int k = 0; k < SRC_PER_EP; k++)
            src[k] <= 7'h40;
        wr(ADDR_EP_IRQ_PENDING, 8'hff);
        rd(ADDR_EP_IRQ_PENDING, 8'h40);
        for (int k = 0; k < SRC_PER_EP; k++)
        begin
            src[k] <= 7'h00;
            repeat (2) @(posedge clk);
            rd(ADDR_EP_IRQ_PENDING, (k < 4) ? 8'h40 : 8'h00);
        end
        wr(ADDR_IRQ_MASK, 8'h08);
        src[3] <= 7'h08;
        repeat (3) @(posedge clk);
        chk("usb_irq", 8'h00, {7'h00, usb_irq});
        chk("irq", 8'h01, {7'h00, irq});
        wr(ADDR_EP_IRQ_ENABLE, 8'h08);
        chk("usb_irq", 8'h01, {7'h00, usb_irq});
        rd(ADDR_EP_IRQ_ENABLE, 8'h08);
        wr(ADDR_IRQ_MASK, 8'h00);
        chk("irq", 8'h00, {7'h00, irq});
        wr(ADDR_IRQ_MASK, 8'h08);
        src[3] <= 7'h00;
        repeat (2) @(posedge clk);
        chk("usb_irq", 8'h00, {7'h00, usb_irq});
        chk("irq", 8'h01, {7'h00, irq});
        wr(ADDR_IRQ_STATUS, 8'h08);
        chk("irq", 8'h00, {7'h00, irq});
        wr(ADDR_EP_SELECT, 8'h05);
        chk("select", 8'h05, {5'h00, sel});
        src[1] <= 7'h20;
        repeat (2) @(posedge clk);
        rd(ADDR_EP_STATUS_WIN, 8'h02);
        rd(ADDR_EP_SELECT, 8'h05);
        rd(ADDR_IRQ_MASK, 8'h08);
        rd(ADDR_IRQ_STATUS, 8'h77);
        wr(ADDR_IRQ_STATUS, 8'hff);
        rd(ADDR_IRQ_STATUS, 8'h00);
        wr(ADDR_EP_SELECT, 8'h07);
        rd(ADDR_EP_STATUS_WIN, 8'h00);
        rd(8'h00, 8'h00);
        finish_test;
    end
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 1000)
        begin
            err_count++;
            finish_test;
        end
    end
endmodule
bind uei_top uei_top_properties u_props (.clk(clk), .rst(rst), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .transmit_complete(transmit_complete), .out_received_bank_a(out_received_bank_a),
    .out_received_bank_b(out_received_bank_b), .setup_received(setup_received),
    .stall_or_crc_error(stall_or_crc_error), .endpoint_select(endpoint_select),
    .usb_irq(usb_irq), .irq(irq));
